/* rtl/acr_defines.svh */
// Register offsets, field positions, reset values and timing counts for the converter control
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_OFF_RUN 12'h000
`define ACR_OFF_CLKREF 12'h004
`define ACR_OFF_RESULT 12'h008
`define ACR_OFF_FLAG 12'h00C
`define ACR_OFF_ENABLE 12'h010
`define ACR_RUN_CHS_LO 2
`define ACR_RUN_START 1
`define ACR_RUN_ENABLE 0
`define ACR_RUN_MASK 8'h3F
`define ACR_CLKREF_MASK 8'h73
`define ACR_IRQ_BIT 6
`define ACR_RST_CLKREF 8'h00
`define ACR_RST_RUN 8'h00
`define ACR_RST_RESULT 8'h00
`define ACR_CONV_STEPS 4'h9
`endif

/* rtl/acr_pkg.sv */
// Types shared by the converter control block
package acr_pkg;
  // Conversion clock choices
  typedef enum logic [2:0] {
    ACR_DIV2 = 3'b000, ACR_DIV8 = 3'b001, ACR_DIV32 = 3'b010, ACR_RC_A = 3'b011,
    ACR_DIV4 = 3'b100, ACR_DIV16 = 3'b101, ACR_DIV64 = 3'b110, ACR_RC_B = 3'b111
  } acr_clk_sel_t;
  // Reference choices presented to the analog side
  typedef enum logic [1:0] {
    ACR_REF_SUPPLY = 2'b00, ACR_REF_PIN = 2'b01, ACR_REF_FIXED = 2'b10
  } acr_ref_t;
  // Converter sequencer states
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00, ACR_CONV = 2'b01, ACR_DONE = 2'b10
  } acr_state_t;
  // Analog control bundle
  typedef struct packed {
    logic powered;
    acr_ref_t ref_sel;
    logic [3:0] input_channel_select;
    logic sample;
  } acr_analog_t;
endpackage : acr_pkg

/* rtl/acr_ctrl.sv */
// APB register block and sequencer for the 8-bit successive approximation converter
//
// Chosen here: register access over APB and the register offsets.
`include "acr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Clock select field picks divider or RC
// - Bit7 and bits3-2 read zero, ignore writes
// - Result register holds full byte, read/write
// - Channel 5-2, start bit1, enable bit0
// - Completion flag and enable at bit6
// - Start bit held while converting, then clears
// - Enable zero keeps converter off
module acr_ctrl import acr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog core
  input wire logic comp_in,
  input wire logic rc_clk_in,
  output acr_analog_t analog_q,
  output logic [7:0] dac_code,
  // Interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // Reset and input synchronisers
  logic rst_s1_q, rst_s2_q; // Released reset copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire srst_n = rst_s2_q;
  logic comp_s1_q, comp_s2_q, rc_s1_q, rc_s2_q, rc_s3_q; // Pin inputs, two stages each
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_in;
      comp_s2_q <= comp_s1_q;
      rc_s1_q <= rc_clk_in;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q; // Edge history, reads only the second stage
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] run_q; // Channel, start, enable
  logic [7:0] clkref_q; // Clock and reference control
  logic [7:0] result_q; // Conversion result
  logic flag_q; // Completion flag
  logic flag_en_q; // Completion interrupt enable
  logic [7:0] sar_q; // Approximation register
  logic [3:0] step_q; // Bit counter
  logic [5:0] div_q; // Conversion clock divider
  logic [1:0] settle_q; // Clocks since the trial code last moved, saturating
  acr_state_t state_q;

  // Bus decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_run = paddr == `ACR_OFF_RUN;
  wire hit_clkref = paddr == `ACR_OFF_CLKREF;
  wire hit_result = paddr == `ACR_OFF_RESULT;
  wire hit_flag = paddr == `ACR_OFF_FLAG;
  wire hit_enable = paddr == `ACR_OFF_ENABLE;
  wire hit_any = hit_run | hit_clkref | hit_result | hit_flag | hit_enable;

  // Conversion clock tick select
  wire [2:0] cs = clkref_q[6:4];
  wire rc_tick = rc_s2_q & ~rc_s3_q;
  logic tick;
  always_comb begin
    case (acr_clk_sel_t'(cs))
      ACR_DIV2: tick = div_q[0:0] == 1'b1;
      ACR_DIV4: tick = div_q[1:0] == 2'h3;
      ACR_DIV8: tick = div_q[2:0] == 3'h7;
      ACR_DIV16: tick = div_q[3:0] == 4'hF;
      ACR_DIV32: tick = div_q[4:0] == 5'h1F;
      ACR_DIV64: tick = div_q == 6'h3F;
      default: tick = rc_tick;
    endcase
  end

  // Reference decode
  wire [1:0] rs = clkref_q[1:0];
  wire acr_ref_t ref_d = !rs[1] ? ACR_REF_SUPPLY :
                         (rs[0] ? ACR_REF_FIXED : ACR_REF_PIN);

  wire enabled = run_q[`ACR_RUN_ENABLE];
  // Software may only start when enabled; acquisition time is its duty
  wire sw_start = wr && hit_run && pwdata[`ACR_RUN_START] && pwdata[`ACR_RUN_ENABLE];
  wire busy = state_q == ACR_CONV;
  // Clearing enable or writing start low stops a running conversion
  wire abort = busy && (!enabled || (wr && hit_run && !pwdata[`ACR_RUN_START]));
  // The comparator crosses two sync stages after the registered trial code moves,
  // so a decision waits four clocks; at the /2 choice each step spans two ticks
  wire settled = settle_q == 2'h3;
  wire advance = tick && settled;
  wire finish = busy && advance && !abort && step_q == (`ACR_CONV_STEPS - 4'h1);
  wire [3:0] bit_idx = step_q - 4'h1; // Step one tries the top bit
  wire [7:0] probe = 8'h80 >> bit_idx; // Zero during the sample step
  wire [7:0] sar_next = (step_q != 4'h0 && comp_s2_q) ? sar_q | probe : sar_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register writes; start bit clears itself at completion
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      run_q <= `ACR_RST_RUN;
      clkref_q <= `ACR_RST_CLKREF;
      flag_en_q <= 1'b0;
    end else begin
      if (wr && hit_run) begin
        run_q <= pwdata[7:0] & `ACR_RUN_MASK;
        run_q[`ACR_RUN_START] <= sw_start && !finish;
      end else if (finish || !enabled) begin
        run_q[`ACR_RUN_START] <= 1'b0;
      end
      if (wr && hit_clkref) clkref_q <= pwdata[7:0] & `ACR_CLKREF_MASK;
      if (wr && hit_enable) flag_en_q <= pwdata[`ACR_IRQ_BIT];
    end
  end

  // Sequencer: sample step then eight trial steps
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      state_q <= ACR_IDLE;
      sar_q <= 8'h00;
      step_q <= 4'h0;
      div_q <= 6'h00;
      settle_q <= 2'h0;
    end else begin
      div_q <= busy ? div_q + 6'h01 : 6'h00;
      settle_q <= (!busy || advance) ? 2'h0 : settle_q + {1'b0, !settled};
      case (state_q)
        ACR_IDLE, ACR_DONE: begin
          // A start written in the completion cycle is lost; one written while done is taken
          if (sw_start) begin
            state_q <= ACR_CONV;
            sar_q <= 8'h00;
            step_q <= 4'h0;
          end else begin
            state_q <= ACR_IDLE;
          end
        end
        ACR_CONV: begin
          if (abort) begin
            state_q <= ACR_IDLE; // Abort leaves result untouched
          end else if (finish) begin
            state_q <= ACR_DONE;
          end else if (advance) begin
            sar_q <= sar_next;
            step_q <= step_q + 4'h1;
          end
        end
        default: state_q <= ACR_IDLE;
      endcase
    end
  end

  // Result load and completion flag (set beats clear)
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      result_q <= `ACR_RST_RESULT;
      flag_q <= 1'b0;
    end else begin
      if (finish) result_q <= sar_next;
      else if (wr && hit_result) result_q <= pwdata[7:0];
      if (finish) flag_q <= 1'b1;
      else if (wr && hit_flag && pwdata[`ACR_IRQ_BIT]) flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_run) rd_d[7:0] = run_q;
    if (hit_clkref) rd_d[7:0] = clkref_q;
    if (hit_result) rd_d[7:0] = result_q;
    if (hit_flag) rd_d[`ACR_IRQ_BIT] = flag_q;
    if (hit_enable) rd_d[`ACR_IRQ_BIT] = flag_en_q;
  end
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      analog_q <= '0;
      dac_code <= 8'h00;
    end else begin
      pready <= psel && !penable; // No wait states
      pslverr <= psel && !penable && !hit_any;
      prdata <= (psel && !penable) ? rd_d : 32'h0000_0000;
      irq <= flag_q && flag_en_q;
      analog_q.powered <= enabled;
      analog_q.ref_sel <= ref_d;
      analog_q.input_channel_select <= run_q[5:2];
      analog_q.sample <= busy && step_q == 4'h0;
      dac_code <= busy ? sar_q | probe : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_clkref_zero_bits: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (clkref_q & ~`ACR_CLKREF_MASK) == 8'h00) else $error("Reserved control bits set");
  a_start_held_busy: assert property (@(posedge ref_clk) disable iff (!srst_n)
    busy && !finish && enabled && !wr |=> run_q[`ACR_RUN_START]) else $error("Start dropped");
  a_start_clears: assert property (@(posedge ref_clk) disable iff (!srst_n)
    finish && !wr |=> !run_q[`ACR_RUN_START]) else $error("Start not cleared");
  a_result_loaded: assert property (@(posedge ref_clk) disable iff (!srst_n)
    finish |=> result_q == $past(sar_next) && flag_q) else $error("Result or flag missing");
  a_irq_gated: assert property (@(posedge ref_clk) disable iff (!srst_n)
    irq |-> $past(flag_q) && $past(flag_en_q)) else $error("Ungated interrupt");
  a_power_off: assert property (@(posedge ref_clk) disable iff (!srst_n)
    !enabled |=> !analog_q.powered) else $error("Converter powered while off");
  a_ref_fixed: assert property (@(posedge ref_clk) disable iff (!srst_n)
    clkref_q[1:0] == 2'b11 |=> analog_q.ref_sel == ACR_REF_FIXED) else $error("Bad reference");
  a_ref_supply: assert property (@(posedge ref_clk) disable iff (!srst_n)
    !clkref_q[1] |=> analog_q.ref_sel == ACR_REF_SUPPLY) else $error("Bad supply reference");
  a_div2_tick: assert property (@(posedge ref_clk) disable iff (!srst_n)
    busy && cs == 3'b000 && div_q[0] |-> tick) else $error("Divider tick missing");
  a_trial_settled: assert property (@(posedge ref_clk) disable iff (!srst_n)
    advance && step_q != 4'h0 |-> dac_code == $past(dac_code) && dac_code == $past(dac_code, 2))
    else $error("Decision on unsettled comparator");
endmodule : acr_ctrl

/* dv/acr_ctrl_tb.sv */
// Self-checking bench for the converter control block
`include "acr_defines.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module acr_ctrl_tb import acr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and APB drive
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rc_clk_in = 0, comp_in;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rv;
  logic pready, pslverr, irq, er, ie;
  acr_analog_t analog_q;
  logic [7:0] dac_code, lastv, vin = 8'h00; // Analog input level, last converted level
  int error_cnt = 0, checked = 0, cyc = 0;
  //////////////////////////////////////////////////////////
  acr_ctrl i_acr_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .rc_clk_in(rc_clk_in), .analog_q(analog_q),
    .dac_code(dac_code), .irq(irq));
  always #2 ref_clk = ~ref_clk;
  // Ideal comparator: input at or above the trial code
  assign comp_in = (vin >= dac_code);
  // Cycle count, RC oscillator of six clocks, hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) rc_clk_in <= ~rc_clk_in;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  // Expected clocks per conversion tick
  function automatic int divof(logic [2:0] s);
    case (s)
      3'd0: return 2;
      3'd1: return 8;
      3'd2: return 32;
      3'd4: return 4;
      3'd5: return 16;
      3'd6: return 64;
      default: return 6; // RC codes, bench oscillator period
    endcase
  endfunction : divof
  // Expected reference for a code
  function automatic acr_ref_t refof(logic [1:0] c);
    return (c == 2'b11) ? ACR_REF_FIXED : (c == 2'b10) ? ACR_REF_PIN : ACR_REF_SUPPLY;
  endfunction : refof
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Full conversion with a given divider and reference code
  task automatic conv(input logic [2:0] s, input logic [1:0] rf, input logic [7:0] v);
    int t0;
    int n;
    int per; // Clocks per step; the synchronised comparator needs at least four
    vin <= v;
    lastv = v;
    per = (divof(s) < 4) ? 4 : divof(s);
    apb(1, `ACR_OFF_CLKREF, {25'h0, s, 2'b00, rf});
    apb(1, `ACR_OFF_RUN, 32'h3D); // Channel 15, powered, no start yet
    repeat (20) @(posedge ref_clk); // Acquisition interval
    `CHK("ref", refof(rf), analog_q.ref_sel)
    `CHK("chan", 4'hF, analog_q.input_channel_select)
    `CHK("power", 1'b1, analog_q.powered)
    apb(1, `ACR_OFF_RUN, 32'h3F);
    t0 = cyc;
    n = 0;
    do begin apb(0, `ACR_OFF_RUN, 32'h0); n++; end while (rd[1] === 1'b1 && n < 400);
    `CHK("start", 1'b0, rd[1])
    `CHK("ticks", 1'b1, (cyc - t0 >= 8 * per + 4) && (cyc - t0 <= 9 * per + 12))
    apb(0, `ACR_OFF_RESULT, 32'h0);
    `CHK("result", {24'h0, v}, rd)
    apb(0, `ACR_OFF_FLAG, 32'h0);
    `CHK("flag", 32'h40, rd)
    `CHK("irq", ie, irq)
    apb(1, `ACR_OFF_FLAG, 32'h40); // Write one to clear
    repeat (2) @(posedge ref_clk);
    `CHK("irq clr", 1'b0, irq)
  endtask : conv
  // Verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////
  initial begin
    void'($urandom(28023));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(0, `ACR_OFF_CLKREF, 32'h0);
    `CHK("clkref rst", 32'h0, rd)
    apb(0, `ACR_OFF_RUN, 32'h0);
    `CHK("run rst", 32'h0, rd)
    // Unmapped place is refused
    apb(1, 12'h020, 32'hFF);
    apb(0, 12'h020, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    // Reserved bits read zero
    apb(1, `ACR_OFF_CLKREF, 32'hFFFF_FFFF);
    apb(0, `ACR_OFF_CLKREF, 32'h0);
    `CHK("clkref mask", 32'h73, rd)
    // Start with the converter off is ignored
    apb(1, `ACR_OFF_RUN, 32'h02);
    apb(0, `ACR_OFF_RUN, 32'h0);
    `CHK("start off", 32'h0, rd)
    `CHK("unpowered", 1'b0, analog_q.powered)
    // Result is plain storage
    repeat (4) begin
      rv = $urandom;
      apb(1, `ACR_OFF_RESULT, rv);
      apb(0, `ACR_OFF_RESULT, 32'h0);
      `CHK("result rw", {24'h0, rv[7:0]}, rd)
    end
    // Every divider and reference, interrupt enable alternating
    for (int s = 0; s < 8; s++) begin
      ie = s[0];
      apb(1, `ACR_OFF_ENABLE, {25'h0, ie, 6'h0});
      conv(s[2:0], s[1:0], (s == 1) ? 8'hFF : (s == 2) ? 8'h00 : 8'($urandom));
    end
    // Abort by clearing start, then by power off
    apb(1, `ACR_OFF_RUN, 32'h3F);
    apb(0, `ACR_OFF_RUN, 32'h0);
    `CHK("busy start", 32'h3F, rd)
    apb(1, `ACR_OFF_RUN, 32'h01);
    apb(0, `ACR_OFF_RUN, 32'h0);
    `CHK("abort start", 32'h01, rd)
    apb(1, `ACR_OFF_RUN, 32'h3F);
    apb(1, `ACR_OFF_RUN, 32'h00);
    repeat (200) @(posedge ref_clk);
    apb(0, `ACR_OFF_RUN, 32'h0);
    `CHK("abort run", 32'h0, rd)
    apb(0, `ACR_OFF_RESULT, 32'h0);
    `CHK("abort result", {24'h0, lastv}, rd)
    apb(0, `ACR_OFF_FLAG, 32'h0);
    `CHK("abort flag", 32'h0, rd)
    `CHK("abort irq", 1'b0, irq)
    finish_test();
  end
endmodule : acr_ctrl_tb
